// *** maint_any_warning_out_pkg.sv ***
// constants and types shared by the maintenance information monitor
`default_nettype none
package maint_any_warning_out_pkg;
	localparam int NUM_ITEMS = 5;
	localparam int HIST_DEPTH = 16;
	localparam int VAL_W = 16;

	// item order inside the block, with the flag bit number of each item
	localparam int IT_TEMP = 0;
	localparam int IT_OVOLT = 1;
	localparam int IT_UVOLT = 2;
	localparam int IT_TORQUE = 3;
	localparam int IT_SPEED = 4;
	localparam logic [4:0][4:0] ITEM_CODE = {5'h08, 5'h07, 5'h05, 5'h04,
		5'h02};

	// hysteresis: temperature in 1 degC, voltage in 0.1 V, speed in r/min
	localparam logic [15:0] HYST_TEMP = 16'h0005;
	localparam logic [15:0] HYST_VOLT = 16'h0005;
	localparam logic [15:0] HYST_SPEED = 16'h0005;

	// register byte offsets
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_ROUTE = 12'h004;
	localparam logic [4:0][11:0] OFS_TH = {12'h018, 12'h014, 12'h010,
		12'h00c, 12'h008};
	localparam logic [11:0] OFS_FLAGS = 12'h01c;
	localparam logic [11:0] OFS_REMOTE = 12'h020;
	localparam logic [11:0] OFS_HCTL = 12'h024;
	localparam logic [11:0] OFS_HIDX = 12'h028;
	localparam logic [11:0] OFS_HCODE = 12'h02c;
	localparam logic [11:0] OFS_HTIME = 12'h030;
	localparam logic [11:0] OFS_HDATA = 12'h034;

	// field positions
	localparam int CTRL_AUTO_BIT = 0;
	localparam int CTRL_ACT_LSB = 4;
	localparam int FLAGS_ANY_BIT = 0;
	localparam int HCTL_CLEAR_BIT = 0;
	localparam int HCTL_REJCLR_BIT = 1;
	localparam int HCTL_REJ_BIT = 16;
	localparam int HCTL_HMI_BIT = 17;

	// reset values
	localparam logic RST_AUTO = 1'b1;
	localparam logic [4:0] RST_ACTION = 5'h1f;
	localparam logic [4:0] RST_ROUTE = 5'h00;
	localparam logic [4:0][15:0] RST_TH = {16'h0fa0, 16'h00c8, 16'h00b4,
		16'h0190, 16'h0055};

	// timing: history time stamp in ms, led blink step in ms
	localparam int CLK_NS = 4;
	localparam int TICK_NS = 1000000;
	localparam int TICK_CYCLES = (TICK_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [7:0] LED_STEP_MS = 8'hc8;
	localparam logic [3:0] LED_STEPS = 4'ha;
	localparam logic [3:0] LED_ON_FIRST = 4'h0;
	localparam logic [3:0] LED_ON_SECOND = 4'h2;

	typedef struct packed {
		logic [4:0] code;
		logic [31:0] stamp;
		logic [15:0] data;
	} hist_entry_s;
endpackage
`default_nettype wire

// *** maintenance_any_warning_out_flags.sv ***
// maintenance information monitor with flags, led blink and event history
`timescale 1ns/1ns
`default_nettype none

// What this block does
// [R1] a met information condition raises that item's own flag output
// [R2] each flag goes to its direct output pin or to a remote bit
// [R3] host reads every flag state through a register
// [R4] summary output is high while any applied item is generated
// [R5] while generated the orange indicator blinks twice, then pauses
// [R6] information never stops the motor; the stop request stays low
// [R7] item with action off raises only its flag, not summary or led
// [R8] auto clear on by default; flag drops once release condition holds
// [R9] auto clear off keeps the item latched after release
// [R10] history holds up to 16 events, newest first
// [R11] each entry holds code, generation time and measured value
// [R12] host reads history and clears it through registers
// [R13] history is empty after reset
// [R14] history clear is refused while the human interface input is off
// [R15] bit 2 sets at temperature threshold, releases 5 degC below it
// [R16] bit 4 sets at overvoltage threshold, releases 0.5 V below it
// [R17] bit 5 sets at undervoltage threshold, releases 0.5 V above it
// [R18] bit 7 sets at torque threshold, releases below it, no hysteresis
// [R19] bit 8 sets at speed threshold, releases 5 r/min below it
// [R20] a new event is pushed on entry; the oldest drops when full
module maintenance_any_warning_out_flags #(
	parameter int TICK_CYC = maint_any_warning_out_pkg::TICK_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] temp_meas,
	input wire logic [15:0] volt_meas,
	input wire logic [15:0] torque_meas,
	input wire logic [15:0] speed_meas,
	input wire logic human_interface_enable,
	output logic temp_warn_flag,
	output logic overvolt_warn_flag,
	output logic undervolt_warn_flag,
	output logic torque_warn_flag,
	output logic speed_warn_flag,
	output logic [4:0] flag_direct_out,
	output logic any_warning_out,
	output logic power_alarm_led,
	output logic motor_stop_req
);
	typedef struct packed {
		logic hmi_s1;
		logic hmi_s2;
		logic auto_clear;
		logic [4:0] action;
		logic [4:0] route;
		logic [4:0][15:0] th;
		logic [4:0] flags;
		logic [4:0] direct;
		logic any_out;
		logic led;
		logic [4:0] pend;
		logic [15:0][52:0] hist;
		logic [4:0] count;
		logic [3:0] hidx;
		logic rej;
		logic [17:0] ms_div;
		logic [31:0] ms_time;
		logic [7:0] led_ms;
		logic [3:0] led_step;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic stop;
	} state_s;

	localparam logic [17:0] TICK_LAST = 18'(TICK_CYC - 1);

	state_s state_ff;
	state_s nxt_state;
	logic [4:0][15:0] meas;

	assign meas = {speed_meas, torque_meas, undervolt_meas_dummy(volt_meas),
		volt_meas, temp_meas};

	// identity helper so the voltage feeds both voltage items
	function automatic logic [15:0] undervolt_meas_dummy(
		input logic [15:0] v);
		return v;
	endfunction

	// value has dropped at least hy below th
	function automatic logic fell_below(input logic [15:0] v,
		input logic [15:0] th, input logic [15:0] hy);
		return ({1'b0, v} + {1'b0, hy}) <= {1'b0, th};
	endfunction

	// value has risen at least hy above th
	function automatic logic rose_above(input logic [15:0] v,
		input logic [15:0] th, input logic [15:0] hy);
		return {1'b0, v} >= ({1'b0, th} + {1'b0, hy});
	endfunction

	// flag next state: set on condition, drop on release only if auto
	function automatic logic hyst_next(input logic cur, input logic set_c,
		input logic rel_c, input logic auto_c);
		logic r;
		r = set_c;
		if (cur) begin
			r = !(auto_c && rel_c); // [R8] [R9]
		end
		return r;
	endfunction

	// offset is a mapped register
	function automatic logic reg_mapped(input logic [11:0] a);
		logic r;
		r = (a == maint_any_warning_out_pkg::OFS_CTRL) ||
			(a == maint_any_warning_out_pkg::OFS_ROUTE) ||
			(a == maint_any_warning_out_pkg::OFS_FLAGS) ||
			(a == maint_any_warning_out_pkg::OFS_REMOTE) ||
			(a == maint_any_warning_out_pkg::OFS_HCTL) ||
			(a == maint_any_warning_out_pkg::OFS_HIDX) ||
			(a == maint_any_warning_out_pkg::OFS_HCODE) ||
			(a == maint_any_warning_out_pkg::OFS_HTIME) ||
			(a == maint_any_warning_out_pkg::OFS_HDATA);
		for (int k = 0; k < maint_any_warning_out_pkg::NUM_ITEMS; k++) begin
			if (a == maint_any_warning_out_pkg::OFS_TH[k]) begin
				r = 1'b1;
			end
		end
		return r;
	endfunction

	always_comb begin
		logic [4:0] set_c;
		logic [4:0] rel_c;
		logic [4:0] rise;
		logic tick;
		logic access;
		logic done;
		logic wr;
		logic push;
		logic clr_req;
		logic [2:0] pick;
		logic [31:0] rd;
		maint_any_warning_out_pkg::hist_entry_s ent;
		set_c = '0;
		rel_c = '0;
		rise = '0;
		pick = '0;
		rd = '0;
		ent = '0;
		push = 1'b0;
		tick = 1'b0;
		access = 1'b0;
		done = 1'b0;
		wr = 1'b0;
		clr_req = 1'b0;
		nxt_state = state_ff;
		nxt_state.stop = 1'b0; // [R6]

		nxt_state.hmi_s1 = human_interface_enable;
		nxt_state.hmi_s2 = state_ff.hmi_s1;

		// millisecond time base for history stamps and led timing
		tick = (state_ff.ms_div == TICK_LAST);
		if (tick) begin
			nxt_state.ms_div = '0;
			nxt_state.ms_time = state_ff.ms_time + 32'h0000_0001;
		end else begin
			nxt_state.ms_div = state_ff.ms_div + 18'h0_0001;
		end

		// set and release conditions per item
		// a set at v >= th is written as not (v + 1 <= th)
		set_c[maint_any_warning_out_pkg::IT_TEMP] = !fell_below(temp_meas,
			state_ff.th[maint_any_warning_out_pkg::IT_TEMP], 16'h0001); // [R15]
		rel_c[maint_any_warning_out_pkg::IT_TEMP] = fell_below(temp_meas,
			state_ff.th[maint_any_warning_out_pkg::IT_TEMP],
			maint_any_warning_out_pkg::HYST_TEMP); // [R15]
		set_c[maint_any_warning_out_pkg::IT_OVOLT] = !fell_below(volt_meas,
			state_ff.th[maint_any_warning_out_pkg::IT_OVOLT], 16'h0001); // [R16]
		rel_c[maint_any_warning_out_pkg::IT_OVOLT] = fell_below(volt_meas,
			state_ff.th[maint_any_warning_out_pkg::IT_OVOLT],
			maint_any_warning_out_pkg::HYST_VOLT); // [R16]
		set_c[maint_any_warning_out_pkg::IT_UVOLT] = !rose_above(volt_meas,
			state_ff.th[maint_any_warning_out_pkg::IT_UVOLT], 16'h0001); // [R17]
		rel_c[maint_any_warning_out_pkg::IT_UVOLT] = rose_above(volt_meas,
			state_ff.th[maint_any_warning_out_pkg::IT_UVOLT],
			maint_any_warning_out_pkg::HYST_VOLT); // [R17]
		set_c[maint_any_warning_out_pkg::IT_TORQUE] = !fell_below(torque_meas,
			state_ff.th[maint_any_warning_out_pkg::IT_TORQUE], 16'h0001); // [R18]
		rel_c[maint_any_warning_out_pkg::IT_TORQUE] =
			!set_c[maint_any_warning_out_pkg::IT_TORQUE]; // [R18]
		set_c[maint_any_warning_out_pkg::IT_SPEED] = !fell_below(speed_meas,
			state_ff.th[maint_any_warning_out_pkg::IT_SPEED], 16'h0001); // [R19]
		rel_c[maint_any_warning_out_pkg::IT_SPEED] = fell_below(speed_meas,
			state_ff.th[maint_any_warning_out_pkg::IT_SPEED],
			maint_any_warning_out_pkg::HYST_SPEED); // [R19]

		for (int i = 0; i < maint_any_warning_out_pkg::NUM_ITEMS; i++) begin
			nxt_state.flags[i] = hyst_next(state_ff.flags[i], set_c[i],
				rel_c[i], state_ff.auto_clear); // [R1]
		end
		rise = nxt_state.flags & ~state_ff.flags;

		nxt_state.direct = nxt_state.flags & ~state_ff.route; // [R2]
		nxt_state.any_out = |(nxt_state.flags & state_ff.action); // [R4] [R7]

		// led: two blinks then a pause, repeated while generated
		if (state_ff.any_out) begin
			if (tick) begin
				if (state_ff.led_ms == maint_any_warning_out_pkg::LED_STEP_MS - 8'h01)
					begin
					nxt_state.led_ms = '0;
					if (state_ff.led_step ==
						maint_any_warning_out_pkg::LED_STEPS - 4'h1) begin
						nxt_state.led_step = '0;
					end else begin
						nxt_state.led_step = state_ff.led_step + 4'h1;
					end
				end else begin
					nxt_state.led_ms = state_ff.led_ms + 8'h01;
				end
			end
			nxt_state.led = (state_ff.led_step ==
				maint_any_warning_out_pkg::LED_ON_FIRST) ||
				(state_ff.led_step == maint_any_warning_out_pkg::LED_ON_SECOND); // [R5]
		end else begin
			nxt_state.led_ms = '0;
			nxt_state.led_step = '0;
			nxt_state.led = 1'b0; // [R7]
		end

		// apb: one wait state, write and read data at the completing edge
		access = psel && penable;
		done = access && state_ff.pready;
		wr = done && pwrite;
		nxt_state.pready = access && !state_ff.pready;
		clr_req = wr && (paddr == maint_any_warning_out_pkg::OFS_HCTL) &&
			pwdata[maint_any_warning_out_pkg::HCTL_CLEAR_BIT];

		// history clear; a push in the same cycle still lands
		if (clr_req) begin
			if (!state_ff.pslverr) begin
				nxt_state.count = '0; // [R12]
				nxt_state.pend = '0;
			end
		end
		if (wr && (paddr == maint_any_warning_out_pkg::OFS_HCTL) &&
			pwdata[maint_any_warning_out_pkg::HCTL_REJCLR_BIT]) begin
			nxt_state.rej = 1'b0;
		end
		if (clr_req && state_ff.pslverr) begin
			nxt_state.rej = 1'b1; // [R14]
		end

		// queue newly generated items, push the lowest pending one
		for (int i = maint_any_warning_out_pkg::NUM_ITEMS - 1; i >= 0; i--) begin
			if (state_ff.pend[i]) begin
				pick = 3'(i);
				push = 1'b1;
			end
		end
		if (push) begin
			ent.code = maint_any_warning_out_pkg::ITEM_CODE[pick];
			ent.stamp = state_ff.ms_time;
			ent.data = meas[pick]; // [R11]
			nxt_state.hist = {state_ff.hist[14:0], ent}; // [R10] [R20]
			if (nxt_state.count != 5'h10) begin
				nxt_state.count = nxt_state.count + 5'h01; // [R20]
			end
			nxt_state.pend[pick] = 1'b0;
		end
		nxt_state.pend = nxt_state.pend | rise; // [R20]

		if (wr && !state_ff.pslverr) begin
			if (paddr == maint_any_warning_out_pkg::OFS_CTRL) begin
				nxt_state.auto_clear = pwdata[maint_any_warning_out_pkg::CTRL_AUTO_BIT];
				nxt_state.action =
					pwdata[maint_any_warning_out_pkg::CTRL_ACT_LSB +: 5]; // [R7]
			end
			if (paddr == maint_any_warning_out_pkg::OFS_ROUTE) begin
				nxt_state.route = pwdata[4:0]; // [R2]
			end
			if (paddr == maint_any_warning_out_pkg::OFS_HIDX) begin
				nxt_state.hidx = pwdata[3:0];
			end
			for (int i = 0; i < maint_any_warning_out_pkg::NUM_ITEMS; i++) begin
				if (paddr == maint_any_warning_out_pkg::OFS_TH[i]) begin
					nxt_state.th[i] = pwdata[15:0];
				end
			end
		end

		// read mux, captured in the wait cycle
		ent = state_ff.hist[state_ff.hidx];
		case (paddr)
			maint_any_warning_out_pkg::OFS_CTRL: begin
				rd[maint_any_warning_out_pkg::CTRL_AUTO_BIT] = state_ff.auto_clear;
				rd[maint_any_warning_out_pkg::CTRL_ACT_LSB +: 5] = state_ff.action;
			end
			maint_any_warning_out_pkg::OFS_ROUTE: rd[4:0] = state_ff.route;
			maint_any_warning_out_pkg::OFS_FLAGS: begin
				for (int i = 0; i < maint_any_warning_out_pkg::NUM_ITEMS; i++) begin
					rd[maint_any_warning_out_pkg::ITEM_CODE[i]] = state_ff.flags[i]; // [R3]
				end
				rd[maint_any_warning_out_pkg::FLAGS_ANY_BIT] = state_ff.any_out;
			end
			maint_any_warning_out_pkg::OFS_REMOTE: begin
				for (int i = 0; i < maint_any_warning_out_pkg::NUM_ITEMS; i++) begin
					rd[maint_any_warning_out_pkg::ITEM_CODE[i]] =
						state_ff.flags[i] && state_ff.route[i]; // [R2]
				end
			end
			maint_any_warning_out_pkg::OFS_HCTL: begin
				rd[4:0] = state_ff.count;
				rd[maint_any_warning_out_pkg::HCTL_REJ_BIT] = state_ff.rej;
				rd[maint_any_warning_out_pkg::HCTL_HMI_BIT] = state_ff.hmi_s2;
			end
			maint_any_warning_out_pkg::OFS_HIDX: rd[3:0] = state_ff.hidx;
			maint_any_warning_out_pkg::OFS_HCODE: begin
				if ({1'b0, state_ff.hidx} < state_ff.count) begin
					rd[4:0] = ent.code; // [R12]
				end
			end
			maint_any_warning_out_pkg::OFS_HTIME: begin
				if ({1'b0, state_ff.hidx} < state_ff.count) begin
					rd = ent.stamp;
				end
			end
			maint_any_warning_out_pkg::OFS_HDATA: begin
				if ({1'b0, state_ff.hidx} < state_ff.count) begin
					rd[15:0] = ent.data;
				end
			end
			default: begin
				for (int i = 0; i < maint_any_warning_out_pkg::NUM_ITEMS; i++) begin
					if (paddr == maint_any_warning_out_pkg::OFS_TH[i]) begin
						rd[15:0] = state_ff.th[i];
					end
				end
			end
		endcase
		if (access && !state_ff.pready) begin
			nxt_state.prdata = pwrite ? 32'h0000_0000 : rd;
			nxt_state.pslverr = !reg_mapped(paddr) ||
				(pwrite && (paddr == maint_any_warning_out_pkg::OFS_HCTL) &&
				pwdata[maint_any_warning_out_pkg::HCTL_CLEAR_BIT] &&
				!state_ff.hmi_s2); // [R14]
		end else if (done) begin
			nxt_state.prdata = '0;
			nxt_state.pslverr = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= '0; // [R13]
			state_ff.auto_clear <= maint_any_warning_out_pkg::RST_AUTO; // [R8]
			state_ff.action <= maint_any_warning_out_pkg::RST_ACTION;
			state_ff.route <= maint_any_warning_out_pkg::RST_ROUTE;
			state_ff.th <= maint_any_warning_out_pkg::RST_TH;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign prdata = state_ff.prdata;
	assign pready = state_ff.pready;
	assign pslverr = state_ff.pslverr;
	assign temp_warn_flag = state_ff.flags[maint_any_warning_out_pkg::IT_TEMP];
	assign overvolt_warn_flag = state_ff.flags[maint_any_warning_out_pkg::IT_OVOLT];
	assign undervolt_warn_flag = state_ff.flags[maint_any_warning_out_pkg::IT_UVOLT];
	assign torque_warn_flag = state_ff.flags[maint_any_warning_out_pkg::IT_TORQUE];
	assign speed_warn_flag = state_ff.flags[maint_any_warning_out_pkg::IT_SPEED];
	assign flag_direct_out = state_ff.direct;
	assign any_warning_out = state_ff.any_out;
	assign power_alarm_led = state_ff.led;
	// information never requests a stop; alarms live elsewhere
	assign motor_stop_req = state_ff.stop; // [R6]
endmodule // maintenance_any_warning_out_flags
`default_nettype wire

// *** maint_any_warning_out_note_end.sv ***
// spare source of the monitor; it holds no code

// *** maint_any_warning_out_asserts.sv ***
// port assertions for the maintenance information monitor
`timescale 1ns/1ns
`default_nettype none
module maint_any_warning_out_asserts (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic temp_warn_flag,
	input wire logic overvolt_warn_flag,
	input wire logic undervolt_warn_flag,
	input wire logic torque_warn_flag,
	input wire logic speed_warn_flag,
	input wire logic [4:0] flag_direct_out,
	input wire logic any_warning_out,
	input wire logic power_alarm_led,
	input wire logic motor_stop_req
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic [4:0] fv = {speed_warn_flag, torque_warn_flag,
		undervolt_warn_flag, overvolt_warn_flag, temp_warn_flag};
	a_stop_low: assert property (motor_stop_req == 1'b0)
		else $error("stop request raised");
	a_ready_wait: assert property (psel && penable && !pready |=> pready)
		else $error("pready not one cycle after access");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
		else $error("read data outside answer cycle");
	a_route_map: assert property ((flag_direct_out & ~fv) == 5'h00)
		else $error("direct output without its flag");
	a_any_flag: assert property (any_warning_out |-> fv != 5'h00)
		else $error("summary high with no flag");
	a_led_src: assert property ($rose(power_alarm_led) |->
		$past(any_warning_out))
		else $error("led lit without summary");
	a_led_off: assert property (!any_warning_out |=> !power_alarm_led)
		else $error("led lit after summary dropped");
	c_temp: cover property ($rose(temp_warn_flag));
	c_led: cover property ($rose(power_alarm_led));
	c_err: cover property (pslverr);
endmodule // maint_any_warning_out_asserts
bind maintenance_any_warning_out_flags maint_any_warning_out_asserts maint_any_warning_out_asserts_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.temp_warn_flag(temp_warn_flag), .overvolt_warn_flag(overvolt_warn_flag),
	.undervolt_warn_flag(undervolt_warn_flag),
	.torque_warn_flag(torque_warn_flag), .speed_warn_flag(speed_warn_flag),
	.flag_direct_out(flag_direct_out), .any_warning_out(any_warning_out),
	.power_alarm_led(power_alarm_led), .motor_stop_req(motor_stop_req));
`default_nettype wire

// *** host_apb_model.sv ***
// host side model: apb master that reads and clears the monitor
`timescale 1ns/1ns
`default_nettype none
module host_apb_model (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
	end
	// one transfer; bench timeout ends a missing answer
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] rd, output logic err);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 100000);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released lines show no stale value
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule // host_apb_model
`default_nettype wire

// *** maintenance_any_warning_out_flags_tb.sv ***
// self-checking bench for the maintenance information monitor
`timescale 1ns/1ns
`default_nettype none
module maintenance_any_warning_out_flags_tb;
	typedef struct packed {
		logic [15:0] t, v, q, s;
		logic [4:0] e;
	} row_s;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic human_interface_enable = 1'b1;
	logic [15:0] temp_meas = 16'h0020, volt_meas = 16'h00dc;
	logic [15:0] torque_meas = 16'h0010, speed_meas = 16'h0100;
	wire logic psel, penable, pwrite, pready, pslverr;
	wire logic [11:0] paddr;
	wire logic [31:0] pwdata, prdata;
	wire logic tf, of, uf, qf, sf, any_warning_out, power_alarm_led, stp;
	wire logic [4:0] flag_direct_out;
	wire logic [4:0] fv = {sf, qf, uf, of, tf};
	int fails = 0, checks_done = 0, cyc = 0, i;
	logic [31:0] rdv;
	logic [31:0] stamp_new;
	logic err;
	row_s rows [14] = '{
		'{16'h0055, 16'h00dc, 16'h0010, 16'h0100, 5'h01},
		'{16'h0051, 16'h00dc, 16'h0010, 16'h0100, 5'h01},
		'{16'h0050, 16'h00dc, 16'h0010, 16'h0100, 5'h00},
		'{16'h0020, 16'h0190, 16'h0010, 16'h0100, 5'h02},
		'{16'h0020, 16'h018c, 16'h0010, 16'h0100, 5'h02},
		'{16'h0020, 16'h018b, 16'h0010, 16'h0100, 5'h00},
		'{16'h0020, 16'h00b4, 16'h0010, 16'h0100, 5'h04},
		'{16'h0020, 16'h00b8, 16'h0010, 16'h0100, 5'h04},
		'{16'h0020, 16'h00b9, 16'h0010, 16'h0100, 5'h00},
		'{16'h0020, 16'h00dc, 16'h00c8, 16'h0100, 5'h08},
		'{16'h0020, 16'h00dc, 16'h00c7, 16'h0100, 5'h00},
		'{16'h0020, 16'h00dc, 16'h0010, 16'h0fa0, 5'h10},
		'{16'h0020, 16'h00dc, 16'h0010, 16'h0f9c, 5'h10},
		'{16'h0020, 16'h00dc, 16'h0010, 16'h0f9b, 5'h00}};
	maintenance_any_warning_out_flags #(.TICK_CYC(4)) maintenance_any_warning_out_flags_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .temp_meas(temp_meas),
		.volt_meas(volt_meas), .torque_meas(torque_meas),
		.speed_meas(speed_meas),
		.human_interface_enable(human_interface_enable),
		.temp_warn_flag(tf), .overvolt_warn_flag(of),
		.undervolt_warn_flag(uf), .torque_warn_flag(qf),
		.speed_warn_flag(sf), .flag_direct_out(flag_direct_out),
		.any_warning_out(any_warning_out),
		.power_alarm_led(power_alarm_led), .motor_stop_req(stp));
	host_apb_model host_apb_model_i (.pclk(pclk), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	always #2 pclk = ~pclk;
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			give_verdict();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic ee);
		host_apb_model_i.xfer(1'b1, a, d, rdv, err);
		chk("pslverr", 32'(ee), 32'(err));
	endtask
	task automatic rd(input string nm, input logic [11:0] a,
		input logic [31:0] e);
		host_apb_model_i.xfer(1'b0, a, 32'h0000_0000, rdv, err);
		chk(nm, e, rdv);
	endtask
	task automatic meas(input logic [15:0] t, v, q, s);
		@(posedge pclk);
		temp_meas <= t;
		volt_meas <= v;
		torque_meas <= q;
		speed_meas <= s;
		repeat (3) @(posedge pclk);
	endtask
	function automatic logic [31:0] freg(input logic [4:0] e);
		return {23'h00_0000, e[4], e[3], 1'b0, e[2], e[1], 1'b0, e[0],
			1'b0, |e};
	endfunction
	initial begin
		repeat (12) @(posedge pclk);
		chk("outs_in_reset", 32'({fv, any_warning_out, power_alarm_led}), 0);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		rd("hist_ctl", 12'h024, 32'h0002_0000);
		for (i = 0; i < 14; i++) begin
			meas(rows[i].t, rows[i].v, rows[i].q, rows[i].s);
			chk("flags", 32'(fv), 32'(rows[i].e));
			chk("direct", 32'(flag_direct_out), 32'(rows[i].e));
			chk("summary", 32'(any_warning_out), 32'(|rows[i].e));
			chk("stop", 32'(stp), 0);
			rd("flag_reg", 12'h01c, freg(rows[i].e));
		end
		rd("hist_ctl", 12'h024, 32'h0002_0005);
		wr(12'h028, 32'h0000_0000, 1'b0);
		rd("code0", 12'h02c, 32'h0000_0008);
		rd("data0", 12'h034, 32'h0000_0fa0);
		host_apb_model_i.xfer(1'b0, 12'h030, 32'h0000_0000, stamp_new, err);
		wr(12'h028, 32'h0000_0004, 1'b0);
		rd("code4", 12'h02c, 32'h0000_0002);
		rd("data4", 12'h034, 32'h0000_0055);
		host_apb_model_i.xfer(1'b0, 12'h030, 32'h0000_0000, rdv, err);
		chk("stamp_order", 1, 32'(stamp_new > rdv));
		wr(12'h000, 32'h0000_01e1, 1'b0);
		meas(16'h0060, 16'h00dc, 16'h0010, 16'h0100);
		chk("act_off_flag", 32'(tf), 1);
		chk("act_off_out", 32'({any_warning_out, power_alarm_led}), 0);
		meas(16'h0020, 16'h00dc, 16'h0010, 16'h0100);
		wr(12'h000, 32'h0000_01f0, 1'b0);
		meas(16'h0060, 16'h00dc, 16'h0010, 16'h0100);
		meas(16'h0020, 16'h00dc, 16'h0010, 16'h0100);
		chk("latched", 32'(tf), 1);
		wr(12'h000, 32'h0000_01f1, 1'b0);
		repeat (3) @(posedge pclk);
		chk("auto_clear", 32'(tf), 0);
		wr(12'h004, 32'h0000_0001, 1'b0);
		meas(16'h0060, 16'h00dc, 16'h0010, 16'h0100);
		chk("routed_direct", 32'(flag_direct_out), 0);
		rd("remote", 12'h020, 32'h0000_0004);
		// led step is 800 cycles: on, off, on, then a long pause
		for (i = 0; i < 6; i++) begin
			repeat (i == 0 ? 400 : 800) @(posedge pclk);
			chk("led", 32'(power_alarm_led), 32'(i == 0 || i == 2));
		end
		meas(16'h0020, 16'h00dc, 16'h0010, 16'h0100);
		wr(12'h004, 32'h0000_0000, 1'b0);
		@(posedge pclk);
		human_interface_enable <= 1'b0;
		repeat (4) @(posedge pclk);
		wr(12'h024, 32'h0000_0001, 1'b1);
		rd("refused", 12'h024, 32'h0001_0008);
		@(posedge pclk);
		human_interface_enable <= 1'b1;
		repeat (4) @(posedge pclk);
		wr(12'h024, 32'h0000_0003, 1'b0);
		rd("cleared", 12'h024, 32'h0002_0000);
		wr(12'h100, 32'h1234_5678, 1'b1);
		rd("unmapped", 12'h100, 32'h0000_0000);
		chk("unmapped_err", 32'(err), 1);
		// one temperature event, then sixteen load events push it out
		for (i = 0; i < 17; i++) begin
			meas(i == 0 ? 16'h0060 : 16'h0020, 16'h00dc,
				i == 0 ? 16'h0010 : 16'h00c8, 16'h0100);
			meas(16'h0020, 16'h00dc, 16'h0010, 16'h0100);
		end
		rd("full", 12'h024, 32'h0002_0010);
		wr(12'h028, 32'h0000_0000, 1'b0);
		rd("newest", 12'h02c, 32'h0000_0007);
		wr(12'h028, 32'h0000_000f, 1'b0);
		rd("oldest", 12'h02c, 32'h0000_0007);
		// programmable threshold, then a reset in mid-run
		wr(12'h008, 32'h0000_0030, 1'b0);
		meas(16'h0030, 16'h00dc, 16'h0010, 16'h0100);
		chk("th_temp", 32'(tf), 1);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("outs_reset", 32'({fv, any_warning_out, power_alarm_led}), 0);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		rd("hist_reset", 12'h024, 32'h0002_0000);
		rd("th_reset", 12'h008, 32'h0000_0055);
		chk("flags_reset", 32'(fv), 0);
		give_verdict();
	end
endmodule // maintenance_any_warning_out_flags_tb
`default_nettype wire
